//--- inc/cicr_pkg.sv
// Purpose: shared constants for the core interrupt control registers
// Assumes: Avalon-MM byte addressing, 32-bit data, one aligned word per register
// Notes:   8-bit registers sit in the low byte, upper bits read as zero
package cicr_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  localparam int NUM_EXT = 3;
  localparam int PORT_W  = 4;
  localparam int STAT_W  = 5;

  localparam logic [ADDR_W-1:0] OFF_PRIMARY   = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_SECONDARY = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_RESET_CTL = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_MASK      = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_PORT_B    = 5'h14;

  // primary register fields
  localparam int BIT_GLOBAL_EN  = 7;
  localparam int BIT_PERIPH_EN  = 6;
  localparam int BIT_TIMER0_REGISTER_EN    = 5;
  localparam int BIT_EXT0_EN    = 4;
  localparam int BIT_PORT_EN    = 3;
  localparam int BIT_TIMER0_REGISTER_FLAG  = 2;
  localparam int BIT_EXT0_FLAG  = 1;
  localparam int BIT_PORT_FLAG  = 0;

  // secondary register fields
  localparam int BIT_PULLUP_DIS = 7;
  localparam int BIT_EDGE_SEL0  = 6;
  localparam int BIT_TIMER0_REGISTER_PRIO  = 2;
  localparam int BIT_PORT_PRIO  = 0;

  // reset control register field
  localparam int BIT_PRIO_LEVELS = 7;

  // status and mask layout
  localparam int STAT_TIMER0_REGISTER = 0;
  localparam int STAT_EXT0 = 1;
  localparam int STAT_PORT = 2;
  localparam int STAT_EXT1 = 3;
  localparam int STAT_EXT2 = 4;

  localparam logic [REG_W-1:0]  PRIMARY_RST   = 8'h00;
  localparam logic [REG_W-1:0]  SECONDARY_RST = 8'hf5;
  localparam logic [REG_W-1:0]  SECONDARY_WM  = 8'hf5;
  localparam logic [STAT_W-1:0] STAT_RST      = 5'h00;
  localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0000_0000;
endpackage

//--- rtl/cicr_sync.sv
// Purpose: two-stage synchroniser for asynchronous pin inputs
// Assumes: one clock; stages keep running through reset
// Notes:   only the second stage is visible outside; after reset it already holds the pin level
`timescale 1ns/10ps
module cicr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;

  // no reset: a cleared stage would show a false edge when a pin idles high
  always_ff @(posedge clk_sys) begin
    stage1 <= d;
    q      <= stage1;
  end
endmodule

//--- rtl/cicr_core.sv
// Purpose: core interrupt control registers with Avalon-MM slave
// Assumes: clk_sys 50 MHz, srst synchronous active high
// Notes:   one wait state per access; interrupt requests are combinational
// Contract
// (RULE_01) priority-levels bit selects two-level priority when set, single level when clear
// (RULE_02) flags set on their events regardless of individual or global enables
// (RULE_03) single level: bit 7 one permits unmasked interrupts, zero blocks all
// (RULE_04) two level: bit 7 one permits high priority, zero disables all
// (RULE_05) single level: bit 6 gates all peripheral interrupts
// (RULE_06) two level: bit 6 gates low-priority interrupts
// (RULE_07) bit 5 enables the timer-0 overflow interrupt
// (RULE_08) bit 4 enables the external interrupt 0
// (RULE_09) bit 3 enables the port-change interrupt
// (RULE_10) bit 2 set on timer-0 overflow, cleared only by software
// (RULE_11) bit 1 set on external interrupt 0 event, held until software clears
// (RULE_12) bit 0 set when any upper port pin changes, held until cleared
// (RULE_13) mismatch keeps setting port flag; port read ends mismatch
// (RULE_14) per-input edge select in secondary register, one rising, zero falling
// (RULE_15) priority bits for timer-0 and port change; unimplemented bits read zero
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
module cicr_core
  import cicr_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              timer0_overflow,
  input  wire logic [NUM_EXT-1:0] external_irq_input,
  input  wire logic [PORT_W-1:0] upper_port_b_pins,
  input  wire logic              periph_high_pending,
  input  wire logic              periph_low_pending,
  output logic                   irq_high_req,
  output logic                   irq_low_req,
  output logic                   port_pullup_disable,
  output logic                   irq
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  logic                bus_ack;
  logic                wr_go;
  logic                rd_go;
  logic                wr_lane0;
  logic [REG_W-1:0]    wbyte;
  logic [4:0]          enables;
  logic [2:0]          flags;
  logic [2:0]          next_flags;
  logic [REG_W-1:0]    secondary;
  logic                priority_levels_enable;
  logic [STAT_W-1:0]   status;
  logic [STAT_W-1:0]   next_status;
  logic [STAT_W-1:0]   mask;
  logic [STAT_W-1:0]   events;
  logic [DATA_W-1:0]   next_readdata;
  logic [REG_W-1:0]    primary_view;
  logic [NUM_EXT-1:0]  ext_sync;
  logic [NUM_EXT-1:0]  ext_prev;
  logic [NUM_EXT-1:0]  ext_event;
  logic [PORT_W-1:0]   port_sync;
  logic [PORT_W-1:0]   port_ref;
  logic                port_mismatch;
  logic                global_or_high_prio_enable;
  logic                peripheral_or_low_prio_enable;
  logic                timer0_overflow_enable;
  logic                ext_irq0_enable;
  logic                port_change_enable;
  logic                timer0_overflow_flag;
  logic                ext_irq0_flag;
  logic                port_change_flag;
  logic                timer0_overflow_priority;
  logic                port_change_priority;
  logic                timer0_register_act;
  logic                ext0_act;
  logic                port_act;

  // bus slave: one wait state, then the request is taken
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  assign wr_go    = avs_write & bus_ack;
  assign rd_go    = avs_read & bus_ack;
  assign wr_lane0 = wr_go & avs_byteenable[0];
  assign wbyte    = avs_writedata[REG_W-1:0];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
    end
  end

  // pin inputs
  cicr_sync #(.W(NUM_EXT)) u_ext_sync (
    .clk_sys (clk_sys),
    .d       (external_irq_input),
    .q       (ext_sync)
  );

  cicr_sync #(.W(PORT_W)) u_port_sync (
    .clk_sys (clk_sys),
    .d       (upper_port_b_pins),
    .q       (port_sync)
  );

  // delay stage follows the synchronised pin through reset, so release
  // brings no false edge when a pin idles high
  always_ff @(posedge clk_sys) begin
    ext_prev <= ext_sync;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_edge
      logic edge_rising;
      assign edge_rising = secondary[BIT_EDGE_SEL0 - gi];
      assign ext_event[gi] = edge_rising ? (ext_sync[gi] & ~ext_prev[gi])  // [RULE_14]
                                         : (~ext_sync[gi] & ext_prev[gi]);
    end
  endgenerate

  // reading the port register copies the pins, which ends the mismatch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      port_ref <= '0;
    end else if (rd_go && reg_hit(avs_address, OFF_PORT_B)) begin
      port_ref <= port_sync;  // [RULE_13]
    end
  end

  assign port_mismatch = port_sync != port_ref;  // [RULE_12]

  // enables of the primary register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enables <= PRIMARY_RST[BIT_GLOBAL_EN:BIT_PORT_EN];
    end else if (wr_lane0 && reg_hit(avs_address, OFF_PRIMARY)) begin
      enables <= wbyte[BIT_GLOBAL_EN:BIT_PORT_EN];
    end
  end

  assign global_or_high_prio_enable    = enables[BIT_GLOBAL_EN - BIT_PORT_EN];
  assign peripheral_or_low_prio_enable = enables[BIT_PERIPH_EN - BIT_PORT_EN];
  assign timer0_overflow_enable        = enables[BIT_TIMER0_REGISTER_EN - BIT_PORT_EN];
  assign ext_irq0_enable               = enables[BIT_EXT0_EN - BIT_PORT_EN];
  assign port_change_enable            = enables[BIT_PORT_EN - BIT_PORT_EN];

  // flags: software write first, hardware set wins over it
  always_comb begin
    next_flags = flags;
    if (wr_lane0 && reg_hit(avs_address, OFF_PRIMARY)) begin
      next_flags = wbyte[BIT_TIMER0_REGISTER_FLAG:BIT_PORT_FLAG];
    end
    if (timer0_overflow) begin
      next_flags[BIT_TIMER0_REGISTER_FLAG] = 1'b1;  // [RULE_10] [RULE_02]
    end
    if (ext_event[0]) begin
      next_flags[BIT_EXT0_FLAG] = 1'b1;  // [RULE_11] [RULE_02]
    end
    if (port_mismatch) begin
      next_flags[BIT_PORT_FLAG] = 1'b1;  // [RULE_12] [RULE_13]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags <= PRIMARY_RST[BIT_TIMER0_REGISTER_FLAG:BIT_PORT_FLAG];
    end else begin
      flags <= next_flags;
    end
  end

  assign timer0_overflow_flag = flags[BIT_TIMER0_REGISTER_FLAG];
  assign ext_irq0_flag        = flags[BIT_EXT0_FLAG];
  assign port_change_flag     = flags[BIT_PORT_FLAG];

  // secondary register, unimplemented bits held at zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      secondary <= SECONDARY_RST;
    end else if (wr_lane0 && reg_hit(avs_address, OFF_SECONDARY)) begin
      secondary <= wbyte & SECONDARY_WM;  // [RULE_15]
    end
  end

  assign port_pullup_disable      = secondary[BIT_PULLUP_DIS];
  assign timer0_overflow_priority = secondary[BIT_TIMER0_REGISTER_PRIO];
  assign port_change_priority     = secondary[BIT_PORT_PRIO];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      priority_levels_enable <= 1'b0;
    end else if (wr_lane0 && reg_hit(avs_address, OFF_RESET_CTL)) begin
      priority_levels_enable <= wbyte[BIT_PRIO_LEVELS];
    end
  end

  // interrupt requests towards the core
  assign timer0_register_act = timer0_overflow_enable & timer0_overflow_flag;  // [RULE_07]
  assign ext0_act = ext_irq0_enable & ext_irq0_flag;               // [RULE_08]
  assign port_act = port_change_enable & port_change_flag;         // [RULE_09]

  always_comb begin
    irq_high_req = 1'b0;
    irq_low_req  = 1'b0;
    if (!priority_levels_enable) begin  // [RULE_01]
      // single level: all requests use the high output
      irq_high_req = global_or_high_prio_enable &  // [RULE_03]
                     (timer0_register_act | ext0_act | port_act |
                      (peripheral_or_low_prio_enable &  // [RULE_05]
                       (periph_high_pending | periph_low_pending)));
    end else begin
      // external 0 has no priority bit and is always high
      irq_high_req = global_or_high_prio_enable &  // [RULE_04] [RULE_15]
                     (ext0_act | (timer0_register_act & timer0_overflow_priority) |
                      (port_act & port_change_priority) | periph_high_pending);
      irq_low_req  = global_or_high_prio_enable & peripheral_or_low_prio_enable &  // [RULE_06]
                     ((timer0_register_act & ~timer0_overflow_priority) |
                      (port_act & ~port_change_priority) | periph_low_pending);
    end
  end

  // sticky status with write-one-to-clear and mask
  assign events[STAT_TIMER0_REGISTER] = timer0_overflow;
  assign events[STAT_EXT0] = ext_event[0];
  assign events[STAT_PORT] = port_mismatch;
  assign events[STAT_EXT1] = ext_event[1];
  assign events[STAT_EXT2] = ext_event[2];

  always_comb begin
    next_status = status;
    if (wr_lane0 && reg_hit(avs_address, OFF_STATUS)) begin
      next_status = status & ~wbyte[STAT_W-1:0];
    end
    next_status = next_status | events;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status <= STAT_RST;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mask <= STAT_RST;
    end else if (wr_lane0 && reg_hit(avs_address, OFF_MASK)) begin
      mask <= wbyte[STAT_W-1:0];
    end
  end

  assign irq = |(status & mask);

  // read path, captured in the wait-state cycle
  assign primary_view = {enables, flags};

  always_comb begin
    next_readdata = READ_ZERO;
    if (reg_hit(avs_address, OFF_PRIMARY)) begin
      next_readdata[REG_W-1:0] = primary_view;
    end else if (reg_hit(avs_address, OFF_SECONDARY)) begin
      next_readdata[REG_W-1:0] = secondary;
    end else if (reg_hit(avs_address, OFF_RESET_CTL)) begin
      next_readdata[BIT_PRIO_LEVELS] = priority_levels_enable;
    end else if (reg_hit(avs_address, OFF_STATUS)) begin
      next_readdata[STAT_W-1:0] = status;
    end else if (reg_hit(avs_address, OFF_MASK)) begin
      next_readdata[STAT_W-1:0] = mask;
    end else if (reg_hit(avs_address, OFF_PORT_B)) begin
      next_readdata[PORT_W-1:0] = port_sync;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_readdata <= READ_ZERO;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= next_readdata;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_req_done;
    !avs_waitrequest;
  endsequence

  chk_bus_answer: assert property (s_req_wait |=> s_req_done)
    else $error("bus request not answered after one wait state");

  chk_timer0_register_flag_set: assert property (timer0_overflow |=> timer0_overflow_flag) // [RULE_10]
    else $error("timer0 overflow did not set its flag");

  chk_timer0_register_flag_hold: assert property ( // [RULE_10]
    timer0_overflow_flag && !(wr_go && reg_hit(avs_address, OFF_PRIMARY))
    |=> timer0_overflow_flag)
    else $error("timer0 flag cleared without a software write");

  chk_ext0_flag_set: assert property ( // [RULE_11]
    $rose(ext_sync[0]) && secondary[BIT_EDGE_SEL0] |=> ext_irq0_flag)
    else $error("rising edge on external input 0 did not set its flag");

  chk_port_mismatch: assert property (port_mismatch |=> port_change_flag) // [RULE_13]
    else $error("port mismatch did not keep the change flag set");

  chk_global_block: assert property ( // [RULE_03]
    !global_or_high_prio_enable |-> !irq_high_req && !irq_low_req)
    else $error("interrupt requested while global enable is clear");

  chk_low_gate: assert property ( // [RULE_06]
    priority_levels_enable && !peripheral_or_low_prio_enable |-> !irq_low_req)
    else $error("low priority request while low enable is clear");

  chk_compat_timer0_register: assert property ( // [RULE_07]
    !priority_levels_enable && global_or_high_prio_enable && timer0_register_act |-> irq_high_req)
    else $error("enabled timer0 interrupt not requested");

  chk_compat_low: assert property (!priority_levels_enable |-> !irq_low_req) // [RULE_01]
    else $error("low request in single level operation");

  chk_sec_reserved: assert property ( // [RULE_15]
    (secondary & ~SECONDARY_WM) == '0)
    else $error("unimplemented secondary bits are set");

  chk_irq_status: assert property ( // [RULE_02]
    $past(events[STAT_TIMER0_REGISTER]) && mask[STAT_TIMER0_REGISTER] |-> irq)
    else $error("masked-in event did not raise irq");

endmodule

//--- tb/cicr_src_model.sv
// Purpose: event sources beside the interrupt control block
// Assumes: one clock; bench requests a timer tick by toggling tick_req
// Notes:   pins change only at clock edges, timer pulse lasts one cycle
`timescale 1ns/10ps
module cicr_src_model (
  input  wire logic       clk_sys,
  input  wire logic       tick_req,
  input  wire logic [2:0] ext_lvl,
  input  wire logic [3:0] port_lvl,
  output logic            timer0_overflow,
  output logic [2:0]      external_irq_input,
  output logic [3:0]      upper_port_b_pins
);
  logic tick_q;
  initial begin
    tick_q = 1'b0;
    timer0_overflow = 1'b0;
    external_irq_input = 3'h0;
    upper_port_b_pins = 4'h0;
  end
  always @(posedge clk_sys) begin
    tick_q <= tick_req;
    timer0_overflow <= tick_req ^ tick_q;
    external_irq_input <= ext_lvl;
    upper_port_b_pins <= port_lvl;
  end
endmodule

//--- tb/core_interrupt_control_regs_tb_top.sv
// Purpose: self-checking bench for the interrupt control registers
// Assumes: bus answers after one wait state, pins pass two sync flops
// Notes:   register and request expectations come from a bench model
`timescale 1ns/10ps
module core_interrupt_control_regs_tb_top;
  import cicr_pkg::*;
  logic              clk_sys = 1'b0;
  logic              srst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hf;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              timer0_overflow;
  logic [2:0]        external_irq_input;
  logic [3:0]        upper_port_b_pins;
  logic              ph = 1'b0;
  logic              pl = 1'b0;
  logic              irq_high_req;
  logic              irq_low_req;
  logic              port_pullup_disable;
  logic              irq;
  logic              tick = 1'b0;
  logic [2:0]        ext_lvl = 3'h0;
  logic [3:0]        port_lvl = 4'h0;
  logic [7:0]        m_prim = PRIMARY_RST;
  logic [7:0]        m_sec = SECONDARY_RST;
  logic              m_rc = 1'b0;
  logic [4:0]        m_st = STAT_RST;
  logic [4:0]        m_mk = 5'h00;
  logic [31:0]       seed = 32'd69929;
  logic [31:0]       r;
  logic [31:0]       q;
  int                n_fail = 0;
  int                comparisons = 0;
  int                cycles = 0;
  int                sb[3] = '{1, 3, 4};

  always #10 clk_sys = ~clk_sys;

  cicr_src_model src (.clk_sys(clk_sys), .tick_req(tick), .ext_lvl(ext_lvl),
    .port_lvl(port_lvl), .timer0_overflow(timer0_overflow),
    .external_irq_input(external_irq_input), .upper_port_b_pins(upper_port_b_pins));

  cicr_core DUT (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer0_overflow(timer0_overflow),
    .external_irq_input(external_irq_input), .upper_port_b_pins(upper_port_b_pins),
    .periph_high_pending(ph), .periph_low_pending(pl), .irq_high_req(irq_high_req),
    .irq_low_req(irq_low_req), .port_pullup_disable(port_pullup_disable), .irq(irq));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_reg(input logic [4:0] a);
    case (a)
      OFF_PRIMARY:   return {24'h0, m_prim};
      OFF_SECONDARY: return {24'h0, m_sec};
      OFF_RESET_CTL: return {24'h0, m_rc, 7'h0};
      OFF_STATUS:    return {27'h0, m_st};
      OFF_MASK:      return {27'h0, m_mk};
      OFF_PORT_B:    return {28'h0, port_lvl};
      default:       return 32'h0;
    endcase
  endfunction

  // expected {high request, low request, irq, pull-up disable}
  function automatic logic [3:0] exp_out();
    logic g, l, t, e, p, hi, lo;
    g = m_prim[7];
    l = m_prim[6];
    t = m_prim[5] & m_prim[2];
    e = m_prim[4] & m_prim[1];
    p = m_prim[3] & m_prim[0];
    if (!m_rc) begin
      hi = g & (t | e | p | (l & (ph | pl)));
      lo = 1'b0;
    end else begin
      hi = g & (e | (t & m_sec[2]) | (p & m_sec[0]) | ph);
      lo = g & l & ((t & ~m_sec[2]) | (p & ~m_sec[0]) | pl);
    end
    return {hi, lo, |(m_st & m_mk), m_sec[7]};
  endfunction

  task automatic report_and_stop();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_vec(input logic [3:0] g, input logic [3:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    avs_byteenable <= be;
    // waitrequest and read data are taken at the rising edge that ends the access
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) n_fail++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'hf);
    case (a)
      OFF_PRIMARY:   m_prim = d;
      OFF_SECONDARY: m_sec = d & SECONDARY_WM;
      OFF_RESET_CTL: m_rc = d[7];
      OFF_STATUS:    m_st = m_st & ~d[4:0];
      OFF_MASK:      m_mk = d[4:0];
      default:       ;
    endcase
  endtask

  task automatic rdm(input logic [4:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
    chk_reg(q, exp_reg(a));
  endtask

  task automatic chk_out();
    @(negedge clk_sys);
    chk_vec({irq_high_req, irq_low_req, irq, port_pullup_disable}, exp_out());
  endtask

  task automatic pin(input int i, input logic v);
    @(posedge clk_sys);
    ext_lvl[i] <= v;
    repeat (6) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    for (int a = 0; a < 32; a += 4) rdm(a[4:0]);
    chk_out();
    wr(5'h18, 8'hff);
    rdm(5'h18);
    $display("test reset done");
    bus(1'b1, OFF_PRIMARY, 32'hff, 4'h0);
    rdm(OFF_PRIMARY);
    @(posedge clk_sys);
    tick <= ~tick;
    repeat (4) @(posedge clk_sys);
    m_prim[2] = 1'b1;
    m_st[0] = 1'b1;
    rdm(OFF_PRIMARY);
    repeat (10) @(posedge clk_sys);
    rdm(OFF_PRIMARY);
    wr(OFF_MASK, 8'h1f);
    chk_out();
    wr(OFF_STATUS, 8'h01);
    chk_out();
    wr(OFF_PRIMARY, 8'h00);
    rdm(OFF_PRIMARY);
    $display("test timer done");
    for (int i = 0; i < 3; i++) begin
      wr(OFF_SECONDARY, m_sec & ~(8'h40 >> i));
      pin(i, 1'b1);
      rdm(OFF_STATUS);
      pin(i, 1'b0);
      m_st[sb[i]] = 1'b1;
      if (i == 0) m_prim[1] = 1'b1;
      rdm(OFF_STATUS);
      rdm(OFF_PRIMARY);
      wr(OFF_STATUS, 8'h01 << sb[i]);
      wr(OFF_SECONDARY, m_sec | (8'h40 >> i));
      pin(i, 1'b1);
      m_st[sb[i]] = 1'b1;
      rdm(OFF_STATUS);
    end
    $display("test edges done");
    @(posedge clk_sys);
    port_lvl <= 4'h5;
    repeat (6) @(posedge clk_sys);
    m_prim[0] = 1'b1;
    m_st[2] = 1'b1;
    rdm(OFF_PRIMARY);
    wr(OFF_PRIMARY, m_prim & 8'hfe);
    m_prim[0] = 1'b1;
    rdm(OFF_PRIMARY);
    rdm(OFF_PORT_B);
    wr(OFF_PRIMARY, m_prim & 8'hfe);
    wr(OFF_STATUS, 8'h04);
    rdm(OFF_PRIMARY);
    rdm(OFF_STATUS);
    $display("test port done");
    for (int k = 0; k < 48; k++) begin
      r = xs();
      @(posedge clk_sys);
      ph <= r[22];
      pl <= r[23];
      wr(OFF_PRIMARY, r[7:0]);
      wr(OFF_SECONDARY, r[15:8]);
      wr(OFF_RESET_CTL, {r[16], 7'h0});
      wr(OFF_MASK, {3'h0, r[21:17]});
      rdm(OFF_SECONDARY);
      chk_out();
    end
    $display("test gating done");
    report_and_stop();
  end
endmodule
